// [hdl/ufcs_uart.v]
// Serial transmitter/receiver with mode and status/control registers
// Notes on behaviour
// [RQ1] Receive polarity invert set means receive line idles low, else high.
// [RQ2] Baud tick gives four pulses per bit when high speed, else sixteen.
// [RQ3] Parity select: 11 nine bits, 10 odd, 01 even, 00 eight plain.
// [RQ4] Stop count select one gives two stop bits, zero gives one.
// [RQ5] Tx event: 00 on load, 10 on load emptying queue, 01 on done with queue empty.
// [RQ6] Tx polarity sets idle low plain; infrared reverses that sense.
// [RQ7] Break request sends start, twelve zeros, stop, then clears itself.
// [RQ8] Tx enable drives pin; clearing aborts, flushes queue, releases pin.
// [RQ9] Tx full flag set while queue cannot take another character.
// [RQ10] Tx all empty set only when shifter and queue are empty.
// [RQ11] Rx event: 11 at four held, 10 at three held, 0x every character.
// [RQ12] Address detect with nine-bit framing keeps only ninth-bit-one characters.
// [RQ13] Rx idle flag set while no character is being received.
// [RQ14] Parity error flag describes the character at the receive queue head.
// [RQ15] Framing error flag describes the character at the receive queue head.
// [RQ16] Overrun set on overflow; software clear flushes receive queue and shifter.
// [RQ17] Data available set while receive queue holds an unread character.
// [RQ18] Infrared coding only works in sixteen-times baud mode.
// [RQ19] Transmit and receive queues are four entries deep.
// [RQ20] Frame is start, data LSB first, optional parity, stop bits.
// [RQ21] Reading received data advances the queue to the next character.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ufcs_regs.vh"

module ufcs_uart (
	// Clock and reset
	input  wire                    sys_clk,
	input  wire                    rst_n,
	// Register port
	input  wire [`UFCS_ADDR_W-1:0] reg_addr,
	input  wire [15:0]             reg_wdata,
	input  wire                    reg_wr,
	input  wire                    reg_rd,
	output reg  [15:0]             reg_rdata,
	// Serial pins
	input  wire                    serial_rx_pin,
	output wire                    serial_tx_pin,
	output wire                    serial_tx_oe_n,
	// Events
	output reg                     tx_irq,
	output reg                     rx_irq
);

	localparam TX_IDLE  = 2'h0;
	localparam TX_SHIFT = 2'h1;
	localparam RX_IDLE  = 2'h0;
	localparam RX_SHIFT = 2'h1;
	localparam RX_STOP  = 2'h2;

	reg  [15:0] mode_reg;
	reg  [15:0] baud_reg;
	reg  [1:0]  tx_irq_select_reg;
	reg         tx_polarity_invert_reg;
	reg         tx_break_request_reg;
	reg         tx_enable_reg;
	reg  [1:0]  rx_irq_select_reg;
	reg         address_detect_enable_reg;
	reg         overrun_error_reg;

	wire        infrared_enable    = mode_reg[`UFCS_MODE_INFRARED_ENABLE];
	wire        rx_polarity_invert = mode_reg[`UFCS_MODE_RXINV];
	wire        baud_high_speed    = mode_reg[`UFCS_MODE_BAUD_HIGH_SPEED];
	wire [1:0]  parity_data_select = mode_reg[`UFCS_MODE_PDSEL_HI:`UFCS_MODE_PDSEL_LO];
	wire        stop_count_select  = mode_reg[`UFCS_MODE_STOP_COUNT_SELECT];
	wire        nine_bit           = (parity_data_select == 2'h3);
	wire        parity_on          = (parity_data_select == 2'h1) || (parity_data_select == 2'h2);
	wire        parity_odd         = (parity_data_select == 2'h2);

	// Baud divider: one tick per oversample clock
	reg  [15:0] brg_cnt_reg;
	wire        os_tick = (brg_cnt_reg == baud_reg);
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			brg_cnt_reg <= 16'h0000;
		else if (os_tick)
			brg_cnt_reg <= 16'h0000;
		else
			brg_cnt_reg <= brg_cnt_reg + 16'h0001;
	end

	// [RQ2] oversample ratio
	wire [4:0] os_ratio = baud_high_speed ? `UFCS_OVS_HIGH : `UFCS_OVS_STD;
	wire [4:0] os_last  = os_ratio - 5'h01;
	wire [4:0] os_mid   = {1'b0, os_ratio[4:1]};

	// [RQ19] transmit queue, four entries of nine bits
	reg  [8:0] txq_mem [0:`UFCS_FIFO_DEPTH-1];
	reg  [1:0] txq_rd_reg;
	reg  [1:0] txq_wr_reg;
	reg  [2:0] txq_cnt_reg;
	// [RQ9] full when four queued
	wire       tx_fifo_full = (txq_cnt_reg == 3'h4);

	reg  [1:0]  tx_state_reg;
	reg  [11:0] tx_shift_reg;
	reg  [4:0]  tx_bits_reg;
	reg  [4:0]  tx_os_reg;
	reg         tx_line_reg;
	reg         tx_last_break_reg;
	wire        tx_push = reg_wr && (reg_addr == `UFCS_OFF_TXDATA) && tx_enable_reg && !tx_fifo_full;
	wire        tx_load = (tx_state_reg == TX_IDLE) && (txq_cnt_reg != 3'h0) && tx_enable_reg;
	wire        tx_bit_end = os_tick && (tx_os_reg == os_last);
	wire        tx_done = (tx_state_reg == TX_SHIFT) && tx_bit_end && (tx_bits_reg == 5'h00);
	// [RQ10] both shifter and queue empty
	wire        tx_all_empty = (tx_state_reg == TX_IDLE) && (txq_cnt_reg == 3'h0);
	wire [8:0]  tx_head = txq_mem[txq_rd_reg];
	wire        tx_par  = (^tx_head[7:0]) ^ parity_odd;

	// [RQ3] [RQ4] [RQ20] frame length and bit pattern, stop ones included
	wire [4:0]  data_bits = nine_bit ? 5'h09 : 5'h08;
	wire [4:0]  frame_bits = 5'h01 + data_bits + {4'h0, parity_on} + 5'h01
		+ {4'h0, stop_count_select};
	// [RQ7] break frame length: start, twelve zeros, stop
	wire [4:0]  break_bits = 5'h01 + {1'b0, `UFCS_BREAK_ZEROS} + 5'h01;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			txq_rd_reg        <= 2'h0;
			txq_wr_reg        <= 2'h0;
			txq_cnt_reg       <= 3'h0;
			tx_state_reg      <= TX_IDLE;
			tx_shift_reg      <= 12'hFFF;
			tx_bits_reg       <= 5'h00;
			tx_os_reg         <= 5'h00;
			tx_line_reg       <= 1'b1;
			tx_last_break_reg <= 1'b0;
		end else if (!tx_enable_reg) begin
			// [RQ8] abort and flush
			txq_rd_reg   <= 2'h0;
			txq_wr_reg   <= 2'h0;
			txq_cnt_reg  <= 3'h0;
			tx_state_reg <= TX_IDLE;
			tx_line_reg  <= 1'b1;
		end else begin
			if (tx_push) begin
				txq_mem[txq_wr_reg] <= reg_wdata[8:0];
				txq_wr_reg          <= txq_wr_reg + 2'h1;
			end
			txq_cnt_reg <= txq_cnt_reg + {2'h0, tx_push} - {2'h0, tx_load};
			if (tx_load) begin
				txq_rd_reg   <= txq_rd_reg + 2'h1;
				tx_state_reg <= TX_SHIFT;
				tx_os_reg    <= 5'h00;
				tx_line_reg  <= 1'b0;
				tx_last_break_reg <= tx_break_request_reg;
				// [RQ7] break replaces the character with zeros
				if (tx_break_request_reg) begin
					tx_shift_reg <= 12'h000;
					tx_bits_reg  <= break_bits - 5'h01;
				end else begin
					if (nine_bit)
						tx_shift_reg <= {3'h7, tx_head};
					else if (parity_on)
						tx_shift_reg <= {3'h7, tx_par, tx_head[7:0]};
					else
						tx_shift_reg <= {4'hF, tx_head[7:0]};
					tx_bits_reg <= frame_bits - 5'h01;
				end
			end else if (tx_state_reg == TX_SHIFT && os_tick) begin
				tx_os_reg <= tx_bit_end ? 5'h00 : tx_os_reg + 5'h01;
				if (tx_bit_end) begin
					// [RQ20] LSB first; break ends on a stop bit
					if (tx_last_break_reg && tx_bits_reg == 5'h01)
						tx_line_reg <= 1'b1;
					else
						tx_line_reg <= tx_shift_reg[0];
					tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
					tx_bits_reg  <= tx_bits_reg - 5'h01;
					if (tx_done) begin
						tx_state_reg <= TX_IDLE;
						tx_line_reg  <= 1'b1;
					end
				end
			end
		end
	end

	// [RQ6] [RQ18] polarity and infrared pulse in the middle oversample slots
	wire ir_active = infrared_enable && !baud_high_speed;
	wire ir_pulse  = !tx_line_reg && (tx_os_reg >= 5'h07) && (tx_os_reg < 5'h0A);
	assign serial_tx_pin  = ir_active ? (ir_pulse ^ tx_polarity_invert_reg)
		: (tx_line_reg ^ tx_polarity_invert_reg);
	// [RQ8] pin driven only while enabled
	assign serial_tx_oe_n = !tx_enable_reg;

	// Receive pin synchroniser
	reg rx_meta_reg;
	reg rx_sync_reg;
	reg rx_prev_reg;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_meta_reg <= serial_rx_pin;
			rx_sync_reg <= rx_meta_reg;
			rx_prev_reg <= rx_sync_reg;
		end
	end
	// [RQ1] normalise to idle high; infrared low pulse marks a zero
	wire rx_level = rx_sync_reg ^ rx_polarity_invert;
	// Start only on a fresh fall, so a polarity change or a low stop never fakes one
	wire rx_start = (rx_prev_reg ^ rx_polarity_invert) && !rx_level;
	wire rx_bit   = ir_active ? 1'b1 : rx_level;
	reg  ir_seen_reg;

	// [RQ19] receive queue: nine data bits plus parity and framing flags
	reg  [10:0] rxq_mem [0:`UFCS_FIFO_DEPTH-1];
	reg  [1:0]  rxq_rd_reg;
	reg  [1:0]  rxq_wr_reg;
	reg  [2:0]  rxq_cnt_reg;
	reg  [1:0]  rx_state_reg;
	reg  [4:0]  rx_os_reg;
	reg  [4:0]  rx_bits_reg;
	reg  [10:0] rx_shift_register;
	reg         rx_framing_error_reg;
	wire        rx_data_available = (rxq_cnt_reg != 3'h0);
	wire [10:0] rx_head = rxq_mem[rxq_rd_reg];
	// [RQ21] read of data advances head
	wire        rx_pop = reg_rd && (reg_addr == `UFCS_OFF_RXDATA) && rx_data_available;
	wire        overrun_error_clear = reg_wr && (reg_addr == `UFCS_OFF_STAT)
		&& !reg_wdata[`UFCS_STA_OVERRUN_ERROR] && overrun_error_reg;
	wire [4:0]  rx_payload = data_bits + {4'h0, parity_on};
	wire        rx_sample = os_tick && (rx_os_reg == os_mid);
	wire        rx_end_bit = os_tick && (rx_os_reg == os_last);
	wire [8:0]  rx_data = nine_bit ? rx_shift_register[10:2]
		: (parity_on ? {1'b0, rx_shift_register[9:2]} : {1'b0, rx_shift_register[10:3]});
	wire        rx_par_bad = parity_on && ((^rx_shift_register[10:2]) ^ parity_odd);
	// [RQ12] address filter in nine-bit mode only
	wire        rx_keep = !(address_detect_enable_reg && nine_bit && !rx_data[8]);
	wire        rx_commit = (rx_state_reg == RX_STOP) && rx_sample && rx_keep;
	wire        rx_store = rx_commit && (rxq_cnt_reg != 3'h4);
	wire        rx_overflow = rx_commit && (rxq_cnt_reg == 3'h4);
	// [RQ13] idle whenever not inside a frame
	wire        rx_idle = (rx_state_reg == RX_IDLE);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxq_rd_reg        <= 2'h0;
			rxq_wr_reg        <= 2'h0;
			rxq_cnt_reg       <= 3'h0;
			rx_state_reg      <= RX_IDLE;
			rx_os_reg         <= 5'h00;
			rx_bits_reg       <= 5'h00;
			rx_shift_register <= 11'h000;
			rx_framing_error_reg       <= 1'b0;
			ir_seen_reg       <= 1'b0;
		end else if (overrun_error_clear) begin
			// [RQ16] clearing overrun empties queue and shifter
			rxq_rd_reg        <= 2'h0;
			rxq_wr_reg        <= 2'h0;
			rxq_cnt_reg       <= 3'h0;
			rx_state_reg      <= RX_IDLE;
			rx_shift_register <= 11'h000;
		end else begin
			if (ir_active && !rx_level)
				ir_seen_reg <= 1'b1;
			if (rx_store) begin
				rxq_mem[rxq_wr_reg] <= {rx_par_bad, rx_framing_error_reg | !rx_level, rx_data};
				rxq_wr_reg          <= rxq_wr_reg + 2'h1;
			end
			rxq_cnt_reg <= rxq_cnt_reg + {2'h0, rx_store} - {2'h0, rx_pop};
			if (rx_pop)
				rxq_rd_reg <= rxq_rd_reg + 2'h1;
			case (rx_state_reg)
				RX_IDLE: begin
					rx_os_reg   <= 5'h00;
					rx_framing_error_reg <= 1'b0;
					ir_seen_reg <= 1'b0;
					if (rx_start) begin
						rx_state_reg <= RX_SHIFT;
						rx_bits_reg  <= rx_payload;
					end
				end
				RX_SHIFT: begin
					if (os_tick)
						rx_os_reg <= rx_end_bit ? 5'h00 : rx_os_reg + 5'h01;
					// Sample mid-bit, start bit included
					if (rx_sample) begin
						rx_shift_register <= {(ir_active ? !ir_seen_reg : rx_bit),
							rx_shift_register[10:1]};
						ir_seen_reg <= 1'b0;
						rx_bits_reg <= rx_bits_reg - 5'h01;
						if (rx_bits_reg == 5'h00)
							rx_state_reg <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (os_tick)
						rx_os_reg <= rx_end_bit ? 5'h00 : rx_os_reg + 5'h01;
					// [RQ15] missing stop bit is a framing error
					if (rx_sample)
						rx_state_reg <= RX_IDLE;
				end
				default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	// Register writes and hardware-owned control bits
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg                  <= `UFCS_MODE_RESET;
			baud_reg                  <= `UFCS_BAUD_RESET;
			tx_irq_select_reg         <= 2'h0;
			tx_polarity_invert_reg    <= 1'b0;
			tx_break_request_reg      <= 1'b0;
			tx_enable_reg             <= 1'b0;
			rx_irq_select_reg         <= 2'h0;
			address_detect_enable_reg <= 1'b0;
			overrun_error_reg         <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `UFCS_OFF_MODE)
				mode_reg <= reg_wdata & `UFCS_MODE_WMASK;
			if (reg_wr && reg_addr == `UFCS_OFF_BAUD)
				baud_reg <= reg_wdata;
			if (reg_wr && reg_addr == `UFCS_OFF_STAT) begin
				tx_irq_select_reg      <= {reg_wdata[`UFCS_STA_TXISEL1], reg_wdata[`UFCS_STA_TXISEL0]};
				tx_polarity_invert_reg <= reg_wdata[`UFCS_STA_TXINV];
				tx_break_request_reg   <= reg_wdata[`UFCS_STA_TXBRK];
				tx_enable_reg          <= reg_wdata[`UFCS_STA_TXEN];
				rx_irq_select_reg      <= reg_wdata[`UFCS_STA_RXISEL_HI:`UFCS_STA_RXISEL_LO];
				address_detect_enable_reg <= reg_wdata[`UFCS_STA_ADDRESS_DETECT_ENABLE];
			end else if (tx_done && tx_last_break_reg) begin
				// [RQ7] break request clears itself when done
				tx_break_request_reg <= 1'b0;
			end
			// [RQ16] set wins over a software clear
			if (rx_overflow)
				overrun_error_reg <= 1'b1;
			else if (overrun_error_clear)
				overrun_error_reg <= 1'b0;
		end
	end

	// Event pulses
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_irq <= 1'b0;
			rx_irq <= 1'b0;
		end else begin
			// [RQ5] transmit event selection
			case (tx_irq_select_reg)
				2'h0:    tx_irq <= tx_load;
				2'h2:    tx_irq <= tx_load && (txq_cnt_reg == 3'h1) && !tx_push;
				2'h1:    tx_irq <= tx_done && (txq_cnt_reg == 3'h0);
				default: tx_irq <= 1'b0;
			endcase
			// [RQ11] receive event selection
			case (rx_irq_select_reg)
				2'h3:    rx_irq <= rx_store && (rxq_cnt_reg + {2'h0, 1'b1} - {2'h0, rx_pop} == 3'h4);
				2'h2:    rx_irq <= rx_store && (rxq_cnt_reg + {2'h0, 1'b1} - {2'h0, rx_pop} == 3'h3);
				default: rx_irq <= rx_store;
			endcase
		end
	end

	// Read data, one cycle after the strobe
	wire [15:0] stat_view = {tx_irq_select_reg[1], tx_polarity_invert_reg, tx_irq_select_reg[0],
		1'b0, tx_break_request_reg, tx_enable_reg, tx_fifo_full, tx_all_empty,
		rx_irq_select_reg, address_detect_enable_reg, rx_idle,
		// [RQ14] [RQ15] [RQ17] head-of-queue flags
		rx_data_available & rx_head[10], rx_data_available & rx_head[9],
		overrun_error_reg, rx_data_available};
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 16'h0000;
		else if (reg_rd) begin
			case (reg_addr)
				`UFCS_OFF_MODE:   reg_rdata <= mode_reg;
				`UFCS_OFF_STAT:   reg_rdata <= stat_view;
				`UFCS_OFF_RXDATA: reg_rdata <= {7'h00, rx_head[8:0]};
				`UFCS_OFF_BAUD:   reg_rdata <= baud_reg;
				default:          reg_rdata <= 16'h0000;
			endcase
		end else
			reg_rdata <= 16'h0000;
	end

endmodule // ufcs_uart

// [hdl/ufcs_regs.vh]
// Register offsets, field positions, reset values and timing counts of the serial block
`ifndef UFCS_REGS_VH
`define UFCS_REGS_VH

`define UFCS_ADDR_W           4
`define UFCS_OFF_MODE         4'h0
`define UFCS_OFF_STAT         4'h1
`define UFCS_OFF_TXDATA       4'h2
`define UFCS_OFF_RXDATA       4'h3
`define UFCS_OFF_BAUD         4'h4

`define UFCS_MODE_INFRARED_ENABLE        12
`define UFCS_MODE_RXINV       4
`define UFCS_MODE_BAUD_HIGH_SPEED        3
`define UFCS_MODE_PDSEL_HI    2
`define UFCS_MODE_PDSEL_LO    1
`define UFCS_MODE_STOP_COUNT_SELECT       0
`define UFCS_MODE_WMASK       16'h101F

`define UFCS_STA_TXISEL1      15
`define UFCS_STA_TXINV        14
`define UFCS_STA_TXISEL0      13
`define UFCS_STA_TXBRK        11
`define UFCS_STA_TXEN         10
`define UFCS_STA_TXBF         9
`define UFCS_STA_TX_ALL_EMPTY         8
`define UFCS_STA_RXISEL_HI    7
`define UFCS_STA_RXISEL_LO    6
`define UFCS_STA_ADDRESS_DETECT_ENABLE        5
`define UFCS_STA_RX_IDLE        4
`define UFCS_STA_PARITY_ERROR         3
`define UFCS_STA_FRAMING_ERROR         2
`define UFCS_STA_OVERRUN_ERROR         1
`define UFCS_STA_RXDA         0

`define UFCS_MODE_RESET       16'h0000
`define UFCS_BAUD_RESET       16'h0000
`define UFCS_FIFO_DEPTH       4
`define UFCS_OVS_STD          5'h10
`define UFCS_OVS_HIGH         5'h04
`define UFCS_BREAK_ZEROS      4'hC

`endif

// [test/ufcs_uart_sva.sv]
// Port-level assertion checker for the serial block
`timescale 1ns/1ps
`include "ufcs_regs.vh"

module ufcs_uart_chk (
	// Clock and reset
	input wire                    sys_clk,
	input wire                    rst_n,
	// Register port
	input wire [`UFCS_ADDR_W-1:0] reg_addr,
	input wire [15:0]             reg_wdata,
	input wire                    reg_wr,
	input wire                    reg_rd,
	input wire [15:0]             reg_rdata,
	// Serial pins
	input wire                    serial_rx_pin,
	input wire                    serial_tx_pin,
	input wire                    serial_tx_oe_n,
	// Events
	input wire                    tx_irq,
	input wire                    rx_irq
);
	// Shadow of the control bits, so idle levels can be predicted
	reg  [1:0] sel_reg;
	reg        inv_reg;
	reg        ir_reg;
	wire       st_wr = reg_wr && reg_addr == `UFCS_OFF_STAT;
	wire       md_wr = reg_wr && reg_addr == `UFCS_OFF_MODE;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_reg <= 2'h0;
			inv_reg <= 1'b0;
			ir_reg  <= 1'b0;
		end else begin
			if (st_wr) begin
				sel_reg <= {reg_wdata[15], reg_wdata[13]};
				inv_reg <= reg_wdata[14];
			end
			if (md_wr)
				ir_reg <= reg_wdata[12];
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside answer cycle");
	unmapped_rd_a: assert property (reg_rd && reg_addr > `UFCS_OFF_BAUD |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	tx_drive_a: assert property (st_wr && reg_wdata[10] |=> !serial_tx_oe_n)
		else $error("tx pin not driven after enable");
	tx_release_a: assert property (st_wr && !reg_wdata[10] |=> serial_tx_oe_n)
		else $error("tx pin not released after disable");
	tx_idle_lvl_a: assert property ($fell(serial_tx_oe_n) && !ir_reg |-> serial_tx_pin == !inv_reg)
		else $error("wrong tx idle level at enable");
	port_idle_a: assert property (serial_tx_oe_n && $past(serial_tx_oe_n) && !ir_reg
		|-> serial_tx_pin == !inv_reg)
		else $error("released tx pin not idle");
	txirq_pulse_a: assert property (tx_irq |=> !tx_irq)
		else $error("tx event longer than one cycle");
	rxirq_pulse_a: assert property (rx_irq |=> !rx_irq)
		else $error("rx event longer than one cycle");
	txsel_rsvd_a: assert property (sel_reg == 2'b11 && $past(sel_reg) == 2'b11 |-> !tx_irq)
		else $error("tx event with reserved select");

	cover property (tx_irq);
	cover property (rx_irq);
	cover property ($fell(serial_tx_oe_n));
endmodule // ufcs_uart_chk

bind ufcs_uart ufcs_uart_chk u_ufcs_uart_chk (
	.sys_clk        (sys_clk),
	.rst_n          (rst_n),
	.reg_addr       (reg_addr),
	.reg_wdata      (reg_wdata),
	.reg_wr         (reg_wr),
	.reg_rd         (reg_rd),
	.reg_rdata      (reg_rdata),
	.serial_rx_pin  (serial_rx_pin),
	.serial_tx_pin  (serial_tx_pin),
	.serial_tx_oe_n (serial_tx_oe_n),
	.tx_irq         (tx_irq),
	.rx_irq         (rx_irq)
);

// [test/ufcs_serial_peer.sv]
// Behavioural far-end serial device
`timescale 1ns/1ps

module ufcs_serial_peer (
	// Clock
	input wire sys_clk,
	// Serial lines
	input wire serial_tx_pin,
	output reg serial_rx_pin
);
	initial serial_rx_pin = 1'b1;

	// Bits LSB first, then two idle bits
	task send(input [12:0] f, input integer n, input integer per, input inv);
		integer i;
		begin
			for (i = 0; i < n + 2; i = i + 1) begin
				@(posedge sys_clk);
				serial_rx_pin <= (i < n ? f[i] : 1'b1) ^ inv;
				repeat (per - 1) @(posedge sys_clk);
			end
		end
	endtask

	// Sample each bit at its middle
	task get(output [12:0] f, input integer n, input integer per);
		integer i;
		begin
			f = 13'h0000;
			i = 0;
			while (serial_tx_pin === 1'b1 && i < 4000) begin
				@(posedge sys_clk);
				i = i + 1;
			end
			repeat (per / 2) @(posedge sys_clk);
			for (i = 0; i < n; i = i + 1) begin
				repeat (per) @(posedge sys_clk);
				f[i] = serial_tx_pin;
			end
		end
	endtask
endmodule // ufcs_serial_peer

// [test/ufcs_uart_tb.sv]
// Register-level testbench of the serial block
`timescale 1ns/1ps
`include "ufcs_regs.vh"

module ufcs_uart_tb;
	reg         sys_clk;
	reg         rst_n;
	reg  [3:0]  reg_addr;
	reg  [15:0] reg_wdata;
	reg         reg_wr;
	reg         reg_rd;
	wire [15:0] reg_rdata;
	wire        serial_rx_pin;
	wire        serial_tx_pin;
	wire        serial_tx_oe_n;
	wire        tx_irq;
	wire        rx_irq;
	reg  [15:0] rv;
	reg  [15:0] c0;
	reg  [15:0] tx_cnt = 16'h0000;
	reg  [15:0] rx_cnt = 16'h0000;
	reg  [12:0] fr;
	reg  [12:0] ex [0:3];
	integer     i;
	integer     j;
	integer     error_cnt;
	integer     num_checks;

	ufcs_uart u_ufcs_uart (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
		.serial_tx_oe_n(serial_tx_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq));
	ufcs_serial_peer u_ufcs_serial_peer (.sys_clk(sys_clk), .serial_tx_pin(serial_tx_pin),
		.serial_rx_pin(serial_rx_pin));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (tx_irq === 1'b1)
			tx_cnt <= tx_cnt + 16'h0001;
		if (rx_irq === 1'b1)
			rx_cnt <= rx_cnt + 16'h0001;
	end

	// Strobe cycle followed by one idle cycle
	task wr(input [3:0] a, input [15:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge sys_clk);
			reg_wr <= 1'b0;
			@(posedge sys_clk);
		end
	endtask

	task rd(input [3:0] a);
		begin
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge sys_clk);
			reg_rd <= 1'b0;
			@(posedge sys_clk);
			rv = reg_rdata;
		end
	endtask

	task chk(input [15:0] got, input [15:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask

	task end_of_test;
		begin
			$display("Mismatches %0d in %0d checks", error_cnt, num_checks);
			if (error_cnt == 0 && num_checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	// Tests take about 5000 cycles
	initial begin
		repeat (60000) @(posedge sys_clk);
		error_cnt = error_cnt + 1;
		end_of_test;
	end

	initial begin
		rst_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		ex[0] = 13'h01A5;
		ex[1] = 13'h06A5;
		ex[2] = 13'h03A5;
		ex[3] = 13'h07A5;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rd(`UFCS_OFF_STAT);
		chk(rv, 16'h0110);
		rd(4'hF);
		chk(rv, 16'h0000);
		wr(`UFCS_OFF_MODE, 16'hFFEF);
		rd(`UFCS_OFF_MODE);
		chk(rv, 16'h100F);
		wr(`UFCS_OFF_BAUD, 16'h0000);
		// Every framing and every tx event select, one character each
		for (i = 0; i < 4; i = i + 1) begin
			wr(`UFCS_OFF_MODE, {13'h0000, i[1:0], i[0]});
			wr(`UFCS_OFF_STAT, {i[0], 1'b0, i[1], 13'h0400});
			c0 = tx_cnt;
			wr(`UFCS_OFF_TXDATA, 16'h01A5);
			u_ufcs_serial_peer.get(fr, 9 + (i == 1 || i == 2) + i[0] + (i == 3), 16);
			chk(fr, ex[i]);
			repeat (40) @(posedge sys_clk);
			chk(tx_cnt - c0, {15'h0000, i != 3});
		end
		wr(`UFCS_OFF_MODE, 16'h0000);
		wr(`UFCS_OFF_STAT, 16'h0400);
		c0 = tx_cnt;
		fork
			for (i = 0; i < 5; i = i + 1) begin
				u_ufcs_serial_peer.get(fr, 9, 16);
				chk(fr, 13'h0130 + i[12:0]);
			end
			begin
				for (j = 0; j < 6; j = j + 1)
					wr(`UFCS_OFF_TXDATA, 16'h0030 + j[15:0]);
				rd(`UFCS_OFF_STAT);
				chk(rv & 16'h0300, 16'h0200);
			end
		join
		repeat (20) @(posedge sys_clk);
		rd(`UFCS_OFF_STAT);
		chk(rv & 16'h0300, 16'h0100);
		chk(tx_cnt - c0, 16'h0005);
		// Select 10: only loads that leave the queue empty raise an event
		wr(`UFCS_OFF_STAT, 16'h8400);
		c0 = tx_cnt;
		for (j = 0; j < 3; j = j + 1)
			wr(`UFCS_OFF_TXDATA, 16'h0050 + j[15:0]);
		repeat (600) @(posedge sys_clk);
		chk(tx_cnt - c0, 16'h0002);
		wr(`UFCS_OFF_MODE, 16'h0008);
		wr(`UFCS_OFF_TXDATA, 16'h005A);
		u_ufcs_serial_peer.get(fr, 9, 4);
		chk(fr, 13'h015A);
		wr(`UFCS_OFF_MODE, 16'h0000);
		wr(`UFCS_OFF_STAT, 16'h0C00);
		wr(`UFCS_OFF_TXDATA, 16'h0000);
		u_ufcs_serial_peer.get(fr, 13, 16);
		chk(fr, 13'h1000);
		repeat (20) @(posedge sys_clk);
		rd(`UFCS_OFF_STAT);
		chk(rv & 16'h0800, 16'h0000);
		// Abort with one character shifting and one still queued
		wr(`UFCS_OFF_TXDATA, 16'h0011);
		wr(`UFCS_OFF_TXDATA, 16'h0022);
		wr(`UFCS_OFF_STAT, 16'h0000);
		rd(`UFCS_OFF_STAT);
		chk(rv & 16'h0300, 16'h0100);
		chk({15'h0000, serial_tx_oe_n}, 16'h0001);
		wr(`UFCS_OFF_STAT, 16'h4400);
		chk({15'h0000, serial_tx_pin}, 16'h0000);
		wr(`UFCS_OFF_STAT, 16'h0000);
		c0 = rx_cnt;
		fork
			u_ufcs_serial_peer.send(13'h02C6, 10, 16, 1'b0);
			begin
				repeat (80) @(posedge sys_clk);
				rd(`UFCS_OFF_STAT);
				chk(rv & 16'h0011, 16'h0000);
			end
		join
		rd(`UFCS_OFF_STAT);
		chk(rv & 16'h0011, 16'h0011);
		chk(rx_cnt - c0, 16'h0001);
		rd(`UFCS_OFF_RXDATA);
		chk(rv & 16'h01FF, 16'h0063);
		rd(`UFCS_OFF_STAT);
		chk(rv & 16'h0001, 16'h0000);
		// Parity error, framing error, then a clean character
		wr(`UFCS_OFF_MODE, 16'h0002);
		u_ufcs_serial_peer.send(13'h0402, 11, 16, 1'b0);
		u_ufcs_serial_peer.send(13'h0204, 11, 16, 1'b0);
		u_ufcs_serial_peer.send(13'h0406, 11, 16, 1'b0);
		rd(`UFCS_OFF_STAT);
		chk(rv & 16'h000D, 16'h0009);
		rd(`UFCS_OFF_RXDATA);
		chk(rv & 16'h01FF, 16'h0001);
		rd(`UFCS_OFF_STAT);
		chk(rv & 16'h000C, 16'h0004);
		rd(`UFCS_OFF_RXDATA);
		rd(`UFCS_OFF_STAT);
		chk(rv & 16'h000C, 16'h0000);
		rd(`UFCS_OFF_RXDATA);
		chk(rv & 16'h01FF, 16'h0003);
		wr(`UFCS_OFF_MODE, 16'h0000);
		wr(`UFCS_OFF_STAT, 16'h00C0);
		c0 = rx_cnt;
		for (i = 0; i < 5; i = i + 1) begin
			u_ufcs_serial_peer.send({3'b001, 8'h40 + i[7:0], 1'b0}, 10, 16, 1'b0);
			if (i == 3)
				chk(rx_cnt - c0, 16'h0001);
		end
		rd(`UFCS_OFF_STAT);
		chk(rv & 16'h0003, 16'h0003);
		wr(`UFCS_OFF_STAT, 16'h00C0);
		rd(`UFCS_OFF_STAT);
		chk(rv & 16'h0003, 16'h0000);
		wr(`UFCS_OFF_MODE, 16'h0006);
		wr(`UFCS_OFF_STAT, 16'h0020);
		u_ufcs_serial_peer.send(13'h0554, 11, 16, 1'b0);
		u_ufcs_serial_peer.send(13'h06AA, 11, 16, 1'b0);
		rd(`UFCS_OFF_RXDATA);
		chk(rv & 16'h01FF, 16'h0155);
		rd(`UFCS_OFF_STAT);
		chk(rv & 16'h0001, 16'h0000);
		wr(`UFCS_OFF_MODE, 16'h0010);
		u_ufcs_serial_peer.send(13'h0000, 0, 16, 1'b1);
		u_ufcs_serial_peer.send(13'h0278, 10, 16, 1'b1);
		rd(`UFCS_OFF_RXDATA);
		chk(rv & 16'h01FF, 16'h003C);
		end_of_test;
	end
endmodule // ufcs_uart_tb
